// file: rtl/irq_vector_map_upper.sv
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// How it works
// [RULE_01] uart one fault/rx/tx: irq 39-41, vector 32, bits 7-9, eight slot 0
// [RULE_02] i2c one events: irq 42-44, vector 33, bits 10-12, eight slot 1
// [RULE_03] port a/b/c change: irq 45-47, vector 34, bits 13-15, eight slot 2
// [RULE_04] parallel port: irq 48-49, vector 35, bits 16-17, eight slot 3
// [RULE_05] spi two events: irq 50-52, vector 36, bits 18-20, word nine slot 0
// [RULE_06] uart two events: irq 53-55, vector 37, bits 21-23, nine slot 1
// [RULE_07] i2c two: irq 56-58 vector 38; charge unit irq 59 vector 39
// [RULE_08] dma channels 0-3: irq 60-63, vectors 40-43, bits 28-31, word ten
// [RULE_09] dma flags set on edges only; all other sources are persistent
// [RULE_10] flag and enable of a source share one bit position
// [RULE_11] sources absent on a variant never raise their flag
// [RULE_12] flag on event; request needs flag and enable; best priority wins
module irq_vector_map_upper
  import irq_map_pkg::*;
#(
  parameter logic [31:0] PRESENT_MASK = IMPL_MASK
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire evt_t        EVT,
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             IRQ_OUT,
  output req_t             CPU_REQ
);
  // byte enables widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // merge a write into a register under lanes and implemented bits
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    return (old & ~m) | (wd & m);
  endfunction : merge

  logic [31:0] evt_word;
  logic [31:0] flags;
  logic        lost;
  logic        arb_found;
  logic [4:0]  arb_bit;
  logic [KEY_W-1:0] arb_key;

  // bus handshake state
  logic        ack_q, ack_d;
  logic        wreq_q, wreq_d;
  logic [31:0] rdata_q, rdata_d;
  logic        acc_wr, acc_rd;
  logic [31:0] wmask;
  logic [5:0]  widx;

  // software registers
  logic [31:0]      en_q, en_d;
  logic [2:0][31:0] pw_q, pw_d;
  logic [ST_W-1:0]  st_q, st_d, st_set;
  logic [ST_W-1:0]  msk_q, msk_d;
  logic             irq_q, irq_d;
  req_t             cpu_q, cpu_d;
  logic [31:0]      pend;

  // event lines sit directly on their flag bit positions
  assign evt_word = {EVT, 7'h00}; // [RULE_01] [RULE_02] [RULE_03] [RULE_04]

  // request is accepted in the same cycle that waitrequest is low
  assign acc_wr = ack_q & AVS_WRITE;
  assign acc_rd = ack_q & AVS_READ;
  assign wmask  = lane_mask(AVS_BYTEENABLE);
  assign widx   = AVS_ADDRESS[7:WORD_LSB];

  irq_flag_bank #(
    .PRESENT (PRESENT_MASK)
  ) u_flags (
    .clk     (CLK),
    .rst     (RESET),
    .evt     (evt_word),
    .wr_en   (acc_wr && widx == OFS_FLAG[7:WORD_LSB]),
    .wr_data (AVS_WRITEDATA),
    .wr_mask (wmask),
    .flags   (flags),
    .lost    (lost)
  );

  // flag and enable bits pair up position for position
  assign pend = flags & en_q & IMPL_MASK; // [RULE_10] [RULE_12]

  irq_arbiter u_arb (
    .pend  (pend),
    .pw    (pw_q),
    .found (arb_found),
    .bitno (arb_bit),
    .key   (arb_key)
  );

  // bus slave: one wait state, read data captured before the accept edge
  always_comb begin
    ack_d   = (AVS_READ | AVS_WRITE) & ~ack_q;
    wreq_d  = ~ack_d;
    rdata_d = rdata_q;
    if (ack_d && AVS_READ) begin
      case (widx)
        OFS_FLAG[7:WORD_LSB]:   rdata_d = flags;
        OFS_ENABLE[7:WORD_LSB]: rdata_d = en_q;
        OFS_PW8[7:WORD_LSB]:    rdata_d = pw_q[0];
        OFS_PW9[7:WORD_LSB]:    rdata_d = pw_q[1];
        OFS_PW10[7:WORD_LSB]:   rdata_d = pw_q[2];
        OFS_STATUS[7:WORD_LSB]: rdata_d = {{(32-ST_W){1'b0}}, st_q};
        OFS_MASK[7:WORD_LSB]:   rdata_d = {{(32-ST_W){1'b0}}, msk_q};
        default:                rdata_d = RESET_WORD; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ack_q   <= 1'b0;
      wreq_q  <= 1'b1;
      rdata_q <= RESET_WORD;
    end else begin
      ack_q   <= ack_d;
      wreq_q  <= wreq_d;
      rdata_q <= rdata_d;
    end
  end

  // register writes, status events, arbitration result
  always_comb begin
    en_d  = en_q;
    pw_d  = pw_q;
    msk_d = msk_q;
    if (acc_wr) begin
      case (widx)
        OFS_ENABLE[7:WORD_LSB]:
          en_d = merge(en_q, AVS_WRITEDATA, wmask & IMPL_MASK);
        OFS_PW8[7:WORD_LSB]:
          pw_d[0] = merge(pw_q[0], AVS_WRITEDATA, wmask & PRIO_MASK);
        OFS_PW9[7:WORD_LSB]:
          pw_d[1] = merge(pw_q[1], AVS_WRITEDATA, wmask & PRIO_MASK);
        OFS_PW10[7:WORD_LSB]:
          pw_d[2] = merge(pw_q[2], AVS_WRITEDATA, wmask & PRIO_MASK);
        OFS_MASK[7:WORD_LSB]:
          if (AVS_BYTEENABLE[0]) msk_d = AVS_WRITEDATA[ST_W-1:0];
        default: ;
      endcase
    end

    // vector and fields of the winning source; dma gets one vector each
    cpu_d        = '0;
    cpu_d.valid  = arb_found; // [RULE_12]
    cpu_d.irq    = IRQ_BASE + {1'b0, arb_bit}; // [RULE_08]
    cpu_d.vector = VEC_BASE + 6'(src_grp(int'(arb_bit))); // [RULE_07]
    cpu_d.level  = arb_key[KEY_W-1:SUB_W]; // [RULE_05] [RULE_06]
    cpu_d.sub    = arb_key[SUB_W-1:0];
    if (!arb_found) cpu_d = '0;

    // sticky status; only bits returned by the read are cleared
    st_set            = '0;
    st_set[ST_NEWREQ] = cpu_d.valid &&
                        (!cpu_q.valid || cpu_d.irq != cpu_q.irq);
    st_set[ST_LOST]   = lost;
    st_d = st_q;
    if (acc_rd && widx == OFS_STATUS[7:WORD_LSB])
      st_d = st_q & ~rdata_q[ST_W-1:0];
    st_d  = st_d | st_set; // a new event beats the read clear
    irq_d = |(st_d & msk_d);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      en_q  <= RESET_WORD;
      pw_q  <= '0;
      msk_q <= '0;
      st_q  <= '0;
      irq_q <= 1'b0;
      cpu_q <= '0;
    end else begin
      en_q  <= en_d;
      pw_q  <= pw_d;
      msk_q <= msk_d;
      st_q  <= st_d;
      irq_q <= irq_d;
      cpu_q <= cpu_d;
    end
  end

  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wreq_q;
  assign IRQ_OUT         = irq_q;
  assign CPU_REQ         = cpu_q;

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  property p_uart_one;
    (cpu_q.valid && cpu_q.irq >= 6'h27 && cpu_q.irq <= 6'h29)
      |-> cpu_q.vector == 6'h20;
  endproperty
  a_uart_one: assert property (p_uart_one) // [RULE_01]
    else $error("uart one source not on vector 32");

  property p_i2c_one;
    (cpu_q.valid && cpu_q.irq >= 6'h2a && cpu_q.irq <= 6'h2c)
      |-> cpu_q.vector == 6'h21;
  endproperty
  a_i2c_one: assert property (p_i2c_one) // [RULE_02]
    else $error("i2c one source not on vector 33");

  property p_port_chg;
    (cpu_q.valid && cpu_q.irq >= 6'h2d && cpu_q.irq <= 6'h2f)
      |-> cpu_q.vector == 6'h22;
  endproperty
  a_port_chg: assert property (p_port_chg) // [RULE_03]
    else $error("port change source not on vector 34");

  property p_par_port;
    $rose(flags[16]) && en_q[16] && (pend & 32'hfffe_ff80) == 32'h0
      |=> cpu_q.valid && cpu_q.vector == 6'h23 && cpu_q.irq == 6'h30;
  endproperty
  a_par_port: assert property (p_par_port) // [RULE_04]
    else $error("parallel port request not on vector 35");

  property p_spi_two;
    (cpu_q.valid && cpu_q.irq >= 6'h32 && cpu_q.irq <= 6'h34)
      |-> cpu_q.vector == 6'h24 && cpu_q.level == $past(pw_q[1][4:2]);
  endproperty
  a_spi_two: assert property (p_spi_two) // [RULE_05]
    else $error("spi two vector or level wrong");

  property p_uart_two;
    (cpu_q.valid && cpu_q.irq >= 6'h35 && cpu_q.irq <= 6'h37)
      |-> cpu_q.vector == 6'h25 && cpu_q.sub == $past(pw_q[1][9:8]);
  endproperty
  a_uart_two: assert property (p_uart_two) // [RULE_06]
    else $error("uart two vector or sub-priority wrong");

  property p_i2c_two_charge_time_unit_evt;
    cpu_q.valid |-> (cpu_q.irq inside {[6'h38:6'h3a]}) ==
                    (cpu_q.vector == 6'h26) &&
                    (cpu_q.irq == 6'h3b) == (cpu_q.vector == 6'h27);
  endproperty
  a_i2c_two_charge_time_unit_evt: assert property (p_i2c_two_charge_time_unit_evt) // [RULE_07]
    else $error("i2c two or charge unit vector wrong");

  property p_dma;
    (cpu_q.valid && cpu_q.irq >= 6'h3c)
      |-> cpu_q.vector == cpu_q.irq - 6'h14;
  endproperty
  a_dma: assert property (p_dma) // [RULE_08]
    else $error("dma channel vector wrong");

  property p_pair;
    cpu_q.valid |->
      ($past(flags & en_q) & (32'h1 << cpu_q.irq[4:0])) != 32'h0;
  endproperty
  a_pair: assert property (p_pair) // [RULE_10]
    else $error("request without flag and enable at one position");

  property p_req_follow;
    (|pend) |=> cpu_q.valid;
  endproperty
  a_req_follow: assert property (p_req_follow) // [RULE_12]
    else $error("pending source not requested");

  property p_no_req;
    !(|pend) |=> !cpu_q.valid;
  endproperty
  a_no_req: assert property (p_no_req) // [RULE_12]
    else $error("request with nothing pending");

  property p_wait;
    (AVS_READ || AVS_WRITE) && wreq_q |=> !wreq_q ##1 wreq_q;
  endproperty
  a_wait: assert property (p_wait)
    else $error("waitrequest not low for exactly one cycle");

  // an enabled but absent source must never reach the cpu
  property p_absent_req;
    cpu_q.valid |-> ((PRESENT_MASK >> cpu_q.irq[4:0]) & 32'h1) != 32'h0;
  endproperty
  a_absent_req: assert property (p_absent_req) // [RULE_11]
    else $error("request from an absent source");

  // a dropped dma edge is remembered in status one edge later
  property p_lost_seen;
    lost |=> st_q[ST_LOST];
  endproperty
  a_lost_seen: assert property (p_lost_seen) // [RULE_09]
    else $error("lost dma event not recorded");

  // a fresh request always leaves a trace in status
  property p_newreq;
    cpu_q.valid && !$past(cpu_q.valid) |-> st_q[ST_NEWREQ];
  endproperty
  a_newreq: assert property (p_newreq) // [RULE_12]
    else $error("new request not recorded in status");

  // flags stand until software writes the flag word
  property p_flag_stand;
    (|($past(flags) & ~flags))
      |-> $past(acc_wr && widx == OFS_FLAG[7:WORD_LSB]);
  endproperty
  a_flag_stand: assert property (p_flag_stand) // [RULE_12]
    else $error("flag dropped without a software write");
endmodule : irq_vector_map_upper
`default_nettype wire

// file: include/irq_map_pkg.sv
`default_nettype none
package irq_map_pkg;
  // register byte offsets on the slave port
  localparam logic [7:0] OFS_FLAG   = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_PW8    = 8'h08;
  localparam logic [7:0] OFS_PW9    = 8'h0c;
  localparam logic [7:0] OFS_PW10   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK   = 8'h18;
  localparam int         WORD_LSB   = 2;

  // sources live in bits 7..31; lower bits belong to other irq numbers
  localparam logic [31:0] IMPL_MASK    = 32'hffff_ff80;
  localparam logic [31:0] PERSIST_MASK = 32'h0fff_ff80;
  localparam logic [31:0] PRIO_MASK    = 32'h1f1f_1f1f;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam int          SRC_LO       = 7;
  localparam int          SRC_HI       = 31;
  localparam logic [5:0]  IRQ_BASE     = 6'h20;
  localparam logic [5:0]  VEC_BASE     = 6'h20;

  // priority field layout: 3-bit level above a 2-bit sub-priority
  localparam int SLOT_STRIDE  = 8;
  localparam int GRP_PER_WORD = 4;
  localparam int KEY_W        = 5;
  localparam int SUB_W        = 2;
  localparam int NGRP         = 12;
  localparam int GRP_START [NGRP] =
    '{7, 10, 13, 16, 18, 21, 24, 27, 28, 29, 30, 31};

  // status register bits
  localparam int ST_NEWREQ = 0;
  localparam int ST_LOST   = 1;
  localparam int ST_W      = 2;

  // event lines, msb first so that {evt, 7 zeros} lands on flag bits
  typedef struct packed {
    logic dma_chan_three_evt;
    logic dma_chan_two_evt;
    logic dma_chan_one_evt;
    logic dma_chan_zero_evt;
    logic charge_time_unit_evt;
    logic i2c_two_controller_evt;
    logic i2c_two_target_evt;
    logic i2c_two_collision_evt;
    logic uart_two_tx_evt;
    logic uart_two_rx_evt;
    logic uart_two_err_evt;
    logic spi_two_tx_evt;
    logic spi_two_rx_evt;
    logic spi_two_fault_evt;
    logic parallel_port_err_evt;
    logic parallel_port_evt;
    logic port_c_change_evt;
    logic port_b_change_evt;
    logic port_a_change_evt;
    logic i2c_one_controller_evt;
    logic i2c_one_target_evt;
    logic i2c_one_collision_evt;
    logic uart_one_tx_evt;
    logic uart_one_rx_evt;
    logic uart_one_fault_evt;
  } evt_t;

  // request presented to the cpu vectoring logic
  typedef struct packed {
    logic       valid;
    logic [5:0] vector;
    logic [5:0] irq;
    logic [2:0] level;
    logic [1:0] sub;
  } req_t;

  // shared-vector group of a flag bit
  function automatic int src_grp(input int b);
    int g;
    g = 0;
    for (int i = 1; i < NGRP; i++) begin
      if (b >= GRP_START[i]) g = i;
    end
    return g;
  endfunction : src_grp
endpackage : irq_map_pkg
`default_nettype wire

// file: rtl/irq_flag_bank.sv
`timescale 1ns/10ps
`default_nettype none
module irq_flag_bank
  import irq_map_pkg::*;
#(
  parameter logic [31:0] PRESENT = IMPL_MASK
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] evt,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic [31:0] wr_mask,
  output logic      [31:0] flags,
  output logic             lost
);
  logic [31:0] flags_q, flags_d, prev_q, hit;
  logic        lost_q, lost_d;

  // persistent sources set on level, dma sources only on a rising edge
  always_comb begin
    hit     = evt & PRESENT & IMPL_MASK &
              (PERSIST_MASK | (~prev_q & ~PERSIST_MASK)); // [RULE_09]
    flags_d = flags_q;
    if (wr_en) flags_d = (flags_q & ~wr_mask) | (wr_data & wr_mask);
    // set beats a software clear in the same cycle
    flags_d = (flags_d | hit) & PRESENT & IMPL_MASK; // [RULE_12] [RULE_11]
    lost_d  = |(hit & flags_q & ~PERSIST_MASK);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= RESET_WORD;
      prev_q  <= RESET_WORD;
      lost_q  <= 1'b0;
    end else begin
      flags_q <= flags_d;
      prev_q  <= evt;
      lost_q  <= lost_d;
    end
  end

  assign flags = flags_q;
  assign lost  = lost_q;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_edge_only;
    $rose(flags_q[28]) |-> ($past(evt[28]) && !$past(prev_q[28])) ||
                           $past(wr_en);
  endproperty
  a_edge_only: assert property (p_edge_only) // [RULE_09]
    else $error("dma flag set without an event edge");

  property p_persist;
    (evt[7] && PRESENT[7]) |=> flags_q[7];
  endproperty
  a_persist: assert property (p_persist) // [RULE_09]
    else $error("persistent flag not held by active event");

  property p_absent;
    (flags_q & ~PRESENT) == 32'h0000_0000;
  endproperty
  a_absent: assert property (p_absent) // [RULE_11]
    else $error("absent source raised its flag");
endmodule : irq_flag_bank
`default_nettype wire

// file: rtl/irq_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
module irq_arbiter
  import irq_map_pkg::*;
(
  input  wire logic [31:0]      pend,
  input  wire logic [2:0][31:0] pw,
  output logic                  found,
  output logic [4:0]            bitno,
  output logic [KEY_W-1:0]      key
);
  // highest level, then highest sub; a tie goes to the lower irq
  always_comb begin
    int g;
    logic [KEY_W-1:0] k;
    g     = 0;
    k     = '0;
    found = 1'b0;
    bitno = '0;
    key   = '0;
    for (int b = SRC_LO; b <= SRC_HI; b++) begin
      g = src_grp(b);
      k = pw[g / GRP_PER_WORD][(g % GRP_PER_WORD) * SLOT_STRIDE +: KEY_W];
      if (pend[b] && (!found || k > key)) begin // [RULE_12]
        found = 1'b1;
        bitno = 5'(b);
        key   = k;
      end
    end
  end
endmodule : irq_arbiter
`default_nettype wire

// file: tb/evt_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module evt_src_model
  import irq_map_pkg::*;
(
  input  wire logic clk,
  input  wire evt_t hold,
  input  wire evt_t shot,
  input  wire logic fire,
  output var  evt_t evt
);
  // peripheral lines start quiet so the first edges are clean
  initial evt = '0;

  // held levels plus one-cycle shots, launched from the clock edge
  always @(posedge clk) begin
    evt <= hold | (fire ? shot : '0);
  end
endmodule : evt_src_model
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
  import irq_map_pkg::*;
;
  localparam logic [31:0] PRES = 32'hffff_df80; // port a change absent
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'hf;
  logic [31:0] rdat;
  logic        wait_rq;
  logic        irq_out;
  req_t        cpu_req;
  evt_t        evt;
  evt_t        hold = '0;
  evt_t        shot = '0;
  logic        fire = 1'b0;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          seed = 32'h0ccf;
  logic [31:0] pw [3];
  logic [31:0] f, e, r;

  irq_vector_map_upper #(.PRESENT_MASK(PRES)) dut_u (
    .CLK(clk), .RESET(reset), .EVT(evt), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_rq), .IRQ_OUT(irq_out), .CPU_REQ(cpu_req));

  evt_src_model src_u (
    .clk(clk), .hold(hold), .shot(shot), .fire(fire), .evt(evt));

  // 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_req(input req_t got, input req_t exp);
    chk_word(32'(got), 32'(exp));
  endtask : chk_req

  // one access; waitrequest and read data taken at the rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_rq !== 1'b0 && n < 64);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 64) mismatches++;
  endtask : bus

  // flag lands one edge after the event, the request one edge later
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic pulse(input logic [31:0] m);
    @(posedge clk);
    shot <= m[31:7];
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    settle();
  endtask : pulse

  // winner: highest level then sub; scanning down keeps the lowest irq
  function automatic req_t model(input logic [31:0] p);
    req_t       q;
    int         g;
    int         best;
    logic [4:0] k;
    q = '0;
    best = -1;
    for (int b = 31; b >= 7; b--) begin
      g = (b < 10) ? 0 : (b < 13) ? 1 : (b < 16) ? 2 : (b < 18) ? 3 :
          (b < 21) ? 4 : (b < 24) ? 5 : (b < 27) ? 6 : b - 20;
      k = 5'(pw[g / 4] >> (8 * (g % 4)));
      if (p[b] && int'(k) >= best) begin
        best = int'(k);
        q = {1'b1, 6'(32 + g), 6'(32 + b), k};
      end
    end
    return q;
  endfunction : model

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a <= 28; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      chk_word(r, 32'h0);
    end
    chk_req(cpu_req, '0);
    // lane 0 only: the upper slots must keep their zeros
    be <= 4'h1;
    bus(1'b1, OFS_PW8, 32'hffff_ffff);
    be <= 4'hf;
    bus(1'b0, OFS_PW8, 32'h0);
    chk_word(r, 32'h0000_001f);
    // random fields and pending sets; frequent ties test the irq order
    for (int i = 0; i < 30; i++) begin
      for (int w = 0; w < 3; w++) begin
        pw[w] = $random(seed);
        bus(1'b1, 8'(8 + 4 * w), pw[w]);
        pw[w] = pw[w] & 32'h1f1f_1f1f;
        bus(1'b0, 8'(8 + 4 * w), 32'h0);
        chk_word(r, pw[w]);
      end
      f = $random(seed) & PRES;
      e = $random(seed);
      bus(1'b1, OFS_FLAG, f);
      bus(1'b1, OFS_ENABLE, e);
      f = f & 32'hffff_ff80;
      e = e & 32'hffff_ff80;
      bus(1'b0, OFS_FLAG, 32'h0);
      chk_word(r, f);
      bus(1'b0, OFS_ENABLE, 32'h0);
      chk_word(r, e);
      settle();
      chk_req(cpu_req, model(f & e));
    end
    // each source alone through its event line
    for (int b = 7; b < 32; b++) begin
      bus(1'b1, OFS_FLAG, 32'h0);
      bus(1'b1, OFS_ENABLE, 32'h1 << b);
      pulse(32'h1 << b);
      chk_req(cpu_req, model(PRES & (32'h1 << b)));
      bus(1'b0, OFS_FLAG, 32'h0);
      chk_word(r, PRES & (32'h1 << b));
    end
    // all lines held: only level sources come back after a clear
    @(posedge clk);
    hold <= '1;
    settle();
    bus(1'b1, OFS_FLAG, 32'h0);
    settle();
    bus(1'b0, OFS_FLAG, 32'h0);
    chk_word(r, PRES & 32'h0fff_ff80);
    hold <= '0;
    // lost dma edge, masking and clear on read
    bus(1'b1, OFS_ENABLE, 32'h0);
    bus(1'b1, OFS_FLAG, 32'h0);
    bus(1'b1, OFS_MASK, 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0);
    pulse(32'h1000_0000);
    pulse(32'h1000_0000);
    chk_word({31'h0, irq_out}, 32'h0);
    bus(1'b1, OFS_MASK, 32'h3);
    settle();
    chk_word({31'h0, irq_out}, 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk_word(r, 32'h2);
    bus(1'b1, OFS_ENABLE, 32'h100);
    pulse(32'h100);
    chk_req(cpu_req, model(32'h100));
    bus(1'b0, OFS_STATUS, 32'h0);
    chk_word(r, 32'h1);
    settle();
    chk_word({31'h0, irq_out}, 32'h0);
    conclude();
  end

  // watchdog: the sequence needs well under ten thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : tb
`default_nettype wire
